// ===== include/timer16_pkg.sv
package timer16_pkg;

   // register byte addresses on the apb bus
   localparam logic [11:0] CTRL_A_OFS   = 12'h080;
   localparam logic [11:0] CTRL_B_OFS   = 12'h084;
   localparam logic [11:0] COUNT_OFS    = 12'h088;
   localparam logic [11:0] CMP_A_OFS    = 12'h08C;
   localparam logic [11:0] CMP_B_OFS    = 12'h090;
   localparam logic [11:0] CAPT_OFS     = 12'h094;
   localparam logic [11:0] IRQ_STAT_OFS = 12'h098;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h09C;
   localparam logic [11:0] PIN_DIR_OFS  = 12'h0A0;

   // field positions and write masks
   localparam int          CHA_MODE_LSB  = 6;
   localparam int          CHB_MODE_LSB  = 4;
   localparam int          WAVE_HIGH_LSB = 3;
   localparam logic [7:0]  CTRL_A_WMASK  = 8'hF3;
   localparam logic [7:0]  CTRL_B_WMASK  = 8'h1F;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam int          IRQ_OVF       = 0;
   localparam int          IRQ_CMPA      = 1;
   localparam int          IRQ_CMPB      = 2;

   // counter values
   localparam logic [15:0] BOTTOM     = 16'h0000;
   localparam logic [15:0] TOP_MAX    = 16'hFFFF;
   localparam logic [15:0] TOP_8      = 16'h00FF;
   localparam logic [15:0] TOP_9      = 16'h01FF;
   localparam logic [15:0] TOP_10     = 16'h03FF;
   localparam logic [15:0] COUNT_STEP = 16'h0001;

   // waveform modes
   localparam logic [3:0] M_NORMAL    = 4'h0;
   localparam logic [3:0] M_PC8       = 4'h1;
   localparam logic [3:0] M_PC9       = 4'h2;
   localparam logic [3:0] M_PC10      = 4'h3;
   localparam logic [3:0] M_CTC_CMPA  = 4'h4;
   localparam logic [3:0] M_FAST8     = 4'h5;
   localparam logic [3:0] M_FAST9     = 4'h6;
   localparam logic [3:0] M_FAST10    = 4'h7;
   localparam logic [3:0] M_PFC_CAPT  = 4'h8;
   localparam logic [3:0] M_PFC_CMPA  = 4'h9;
   localparam logic [3:0] M_PC_CAPT   = 4'hA;
   localparam logic [3:0] M_PC_CMPA   = 4'hB;
   localparam logic [3:0] M_CTC_CAPT  = 4'hC;
   localparam logic [3:0] M_FAST_CAPT = 4'hE;
   localparam logic [3:0] M_FAST_CMPA = 4'hF;

   // compare output codes
   localparam logic [1:0] OUT_OFF    = 2'h0;
   localparam logic [1:0] OUT_TOGGLE = 2'h1;
   localparam logic [1:0] OUT_CLEAR  = 2'h2;
   localparam logic [1:0] OUT_SET    = 2'h3;

   // tick source codes and divider widths
   localparam logic [2:0] TSEL_STOP  = 3'h0;
   localparam logic [2:0] TSEL_DIV1  = 3'h1;
   localparam logic [2:0] TSEL_DIV8  = 3'h2;
   localparam logic [2:0] TSEL_DIV64 = 3'h3;
   localparam logic [2:0] TSEL_D256  = 3'h4;
   localparam logic [2:0] TSEL_D1024 = 3'h5;
   localparam logic [2:0] TSEL_FALL  = 3'h6;
   localparam logic [2:0] TSEL_RISE  = 3'h7;
   localparam int         DIV_W      = 10;

   typedef enum logic [2:0] {
      KIND_UP = 3'b001, KIND_FAST = 3'b010, KIND_DUAL = 3'b100
   } count_kind_t;
   typedef enum logic [2:0] {
      TOP_FIXED = 3'b001, TOP_CAPT = 3'b010, TOP_CMPA = 3'b100
   } top_src_t;
   typedef enum logic [3:0] {
      AT_NOW = 4'b0001, AT_TOP = 4'b0010, AT_BOT = 4'b0100, AT_MAX = 4'b1000
   } event_at_t;
   typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} dir_t;

   typedef struct packed {
      count_kind_t kind;
      top_src_t    top_src;
      logic [15:0] fixed_top;
      event_at_t   upd_at;
      event_at_t   tov_at;
      logic        a_toggle_ok;
   } mode_info_t;

   function automatic logic [15:0] bits_top(input logic [1:0] b);
      case (b)
         2'h1:    bits_top = TOP_8;
         2'h2:    bits_top = TOP_9;
         default: bits_top = TOP_10;
      endcase
   endfunction : bits_top

   function automatic mode_info_t decode_mode(input logic [3:0] m);
      mode_info_t i;
      i = '{KIND_UP, TOP_FIXED, TOP_MAX, AT_NOW, AT_MAX, 1'b0};
      case (m)
         M_CTC_CMPA: i.top_src = TOP_CMPA;
         M_CTC_CAPT: i.top_src = TOP_CAPT;
         M_PC8, M_PC9, M_PC10: begin
            i = '{KIND_DUAL, TOP_FIXED, bits_top(m[1:0]), AT_TOP, AT_BOT,
                  1'b0};
         end
         M_FAST8, M_FAST9, M_FAST10: begin
            i = '{KIND_FAST, TOP_FIXED, bits_top(m[1:0]), AT_BOT, AT_TOP,
                  1'b0};
         end
         M_PFC_CAPT: i = '{KIND_DUAL, TOP_CAPT, TOP_MAX, AT_BOT, AT_BOT, 1'b0};
         M_PFC_CMPA: i = '{KIND_DUAL, TOP_CMPA, TOP_MAX, AT_BOT, AT_BOT, 1'b1};
         M_PC_CAPT:  i = '{KIND_DUAL, TOP_CAPT, TOP_MAX, AT_TOP, AT_BOT, 1'b0};
         M_PC_CMPA:  i = '{KIND_DUAL, TOP_CMPA, TOP_MAX, AT_TOP, AT_BOT, 1'b1};
         M_FAST_CAPT: i = '{KIND_FAST, TOP_CAPT, TOP_MAX, AT_BOT, AT_TOP, 1'b1};
         M_FAST_CMPA: i = '{KIND_FAST, TOP_CMPA, TOP_MAX, AT_BOT, AT_TOP, 1'b1};
         default: ;
      endcase
      decode_mode = i;
   endfunction : decode_mode

endpackage : timer16_pkg

// ===== rtl/tick_prescaler.sv
module tick_prescaler
   import timer16_pkg::*;
#(
   parameter int unsigned PRE_W = DIV_W
)(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // source choice and pin
   input  wire logic [2:0] tick_source_select,
   input  wire logic       tick_pin,
   // tick enable out
   output logic            timer_tick_enable
);

   if (PRE_W < DIV_W) begin : g_chk
      $error("prescaler too narrow for the largest divider");
   end

   typedef struct packed {
      logic [PRE_W-1:0] div;
      logic [2:0]       sync;
   } pre_t;

   pre_t s_q, s_d;

   always_comb begin
      s_d      = s_q;
      s_d.div  = s_q.div + PRE_W'(1);
      // stage 0 feeds stage 1 only; edges are seen between stages 1 and 2
      s_d.sync = {s_q.sync[1:0], tick_pin};
      case (tick_source_select)
         TSEL_DIV1:  timer_tick_enable = 1'b1;
         TSEL_DIV8:  timer_tick_enable = &s_q.div[2:0];
         TSEL_DIV64: timer_tick_enable = &s_q.div[5:0];
         TSEL_D256:  timer_tick_enable = &s_q.div[7:0];
         TSEL_D1024: timer_tick_enable = &s_q.div[9:0];
         TSEL_FALL:  timer_tick_enable = s_q.sync[2] & ~s_q.sync[1];
         TSEL_RISE:  timer_tick_enable = ~s_q.sync[2] & s_q.sync[1];
         default:    timer_tick_enable = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : tick_prescaler

// ===== rtl/chan_wave_unit.sv
module chan_wave_unit
   import timer16_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // counter events
   input  wire logic        match,
   input  wire logic        bottom_evt,
   input  wire logic        dir_up,
   input  wire count_kind_t kind,
   input  wire logic        cmp_is_top,
   // configuration
   input  wire logic [1:0]  out_mode,
   input  wire logic        toggle_ok,
   // output
   output logic             wave,
   output logic             takeover
);

   typedef struct packed {logic wave;} unit_t;
   unit_t s_q, s_d;

   always_comb begin
      s_d      = s_q;
      takeover = (out_mode != OUT_OFF);
      case (kind)
         KIND_FAST: begin
            if (out_mode == OUT_TOGGLE && !toggle_ok) takeover = 1'b0;
            if (bottom_evt && out_mode[1]) s_d.wave = (out_mode == OUT_CLEAR);
            // a compare at top would fight the bottom action, so skip it
            if (match && out_mode[1] && !cmp_is_top) begin
               s_d.wave = (out_mode == OUT_SET);
            end
            if (match && takeover && out_mode == OUT_TOGGLE) begin
               s_d.wave = ~s_q.wave;
            end
         end
         KIND_DUAL: begin
            if (out_mode == OUT_TOGGLE && !toggle_ok) takeover = 1'b0;
            if (match && out_mode[1]) begin
               s_d.wave = ((out_mode == OUT_SET) == dir_up);
            end
            if (match && takeover && out_mode == OUT_TOGGLE) begin
               s_d.wave = ~s_q.wave;
            end
         end
         default: begin
            if (match) begin
               case (out_mode)
                  OUT_TOGGLE: s_d.wave = ~s_q.wave;
                  OUT_CLEAR:  s_d.wave = 1'b0;
                  OUT_SET:    s_d.wave = 1'b1;
                  default:    s_d.wave = s_q.wave;
               endcase
            end
         end
      endcase
      wave = s_q.wave;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   nonpwm_set_a: assert property (
      kind == KIND_UP && match && out_mode == OUT_SET |=> wave)
      else $error("set on match not seen");
   fast_bottom_a: assert property (
      kind == KIND_FAST && bottom_evt && !match && out_mode == OUT_CLEAR
      |=> wave)
      else $error("bottom set missing in fast pwm");
   top_ignore_a: assert property (
      kind == KIND_FAST && match && cmp_is_top && out_mode[1] && !bottom_evt
      |=> $stable(wave))
      else $error("match at top not ignored");
   dual_up_clr_a: assert property (
      kind == KIND_DUAL && match && dir_up && out_mode == OUT_CLEAR
      |=> !wave)
      else $error("up-count clear missing");

endmodule : chan_wave_unit

// ===== rtl/timer16_waveform_mode_ctrl.sv
// Function
// - all logic on core clock, counting gated by tick
// - control a holds channel modes, mode low
// - nonzero channel mode hands pin to waveform, except pwm toggle without toggle_ok
// - non-pwm: off, toggle, clear, set on match
// - fast pwm: clear/set on match, inverse at bottom
// - fast pwm: clear/set match at top ignored
// - dual slope: direction decides clear or set
// - mode is control b high plus a low
// - normal and ctc: immediate update, overflow at max
// - modes 1-3 phase correct, fixed top
// - modes 5-7,14,15 fast pwm, load at bottom
// - modes 8,9 load and overflow at bottom
// - modes 10,11 load at top, overflow bottom
// - bottom events timed like top events
// - dual slope holds top one tick
// - mode high bits at control b 4:3
// - tick source: stop, dividers or pin edge
module timer16_waveform_mode_ctrl
   import timer16_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // apb slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // external tick pin
   input  wire logic        tick_pin,
   // compare output pins
   output logic             chan_a_wave_pin_o,
   output logic             chan_a_wave_pin_oe_n,
   output logic             chan_a_takeover,
   output logic             chan_b_wave_pin_o,
   output logic             chan_b_wave_pin_oe_n,
   output logic             chan_b_takeover,
   // interrupt
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [15:0] count;
      logic [15:0] cmp_a_buf;
      logic [15:0] cmp_b_buf;
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
      logic [15:0] capt;
      logic [2:0]  stat;
      logic [2:0]  mask;
      logic [1:0]  pin_dir;
      dir_t        dir;
      logic [1:0]  pend;
      logic        block;
      logic [31:0] rdata;
   } regs_t;

   regs_t       r_q;
   regs_t       r_d;
   mode_info_t  info;
   logic [3:0]  mode;
   logic        tick;
   logic [15:0] top;
   logic        at_top;
   logic        at_bot;
   logic        wr;
   logic        rd_setup;
   logic        cnt_wr;
   logic        tov_evt;
   logic        upd_evt;
   logic [2:0]  set_ev;
   logic [2:0]  clr_ev;
   logic [1:0]  match;
   logic [1:0]  wave;
   logic [1:0]  takeover;
   logic [1:0]  ch_code [2];
   logic [15:0] ch_cmp  [2];

   function automatic logic addr_hit(input logic [11:0] a);
      case (a)
         CTRL_A_OFS, CTRL_B_OFS, COUNT_OFS, CMP_A_OFS, CMP_B_OFS,
         CAPT_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS, PIN_DIR_OFS: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   endfunction : addr_hit

   ////////////////////////////////////////////////////////////////////////
   // tick source

   tick_prescaler u_pre (
      .core_clk           (core_clk),
      .resetn             (resetn),
      .tick_source_select (r_q.ctrl_b[2:0]),
      .tick_pin           (tick_pin),
      .timer_tick_enable  (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // mode decode and counter events

   always_comb begin
      mode = {r_q.ctrl_b[WAVE_HIGH_LSB+:2], r_q.ctrl_a[1:0]};
      info = decode_mode(mode);
      case (info.top_src)
         TOP_CAPT: top = r_q.capt;
         TOP_CMPA: top = r_q.cmp_a;
         default:  top = info.fixed_top;
      endcase
      at_top   = (r_q.count == top);
      at_bot   = (r_q.count == BOTTOM);
      wr       = psel & penable & pwrite;
      rd_setup = psel & ~penable & ~pwrite;
      cnt_wr   = wr && paddr == COUNT_OFS;
      // bottom modes use the same tick-relative timing as top modes
      case (info.tov_at)
         AT_TOP:  tov_evt = tick & at_top;
         AT_BOT:  tov_evt = tick & at_bot;
         default: tov_evt = tick & (r_q.count == TOP_MAX);
      endcase
      case (info.upd_at)
         AT_TOP:  upd_evt = tick & at_top;
         AT_BOT:  upd_evt = tick & at_bot;
         default: upd_evt = 1'b1;
      endcase
      // a software count write masks the next tick's compare
      match[0] = tick & ~r_q.block & (r_q.count == r_q.cmp_a);
      match[1] = tick & ~r_q.block & (r_q.count == r_q.cmp_b);
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      r_d = r_q;

      // counting sequence
      if (tick) begin
         r_d.block = 1'b0;
         if (info.kind == KIND_DUAL) begin
            if (r_q.dir == DIR_UP) begin
               if (at_top) begin
                  r_d.dir   = DIR_DOWN;
                  r_d.count = r_q.count - COUNT_STEP;
               end else begin
                  r_d.count = r_q.count + COUNT_STEP;
               end
            end else begin
               if (at_bot) begin
                  r_d.dir   = DIR_UP;
                  r_d.count = r_q.count + COUNT_STEP;
               end else begin
                  r_d.count = r_q.count - COUNT_STEP;
               end
            end
         end else begin
            r_d.dir = DIR_UP;
            if (at_top) begin
               r_d.count = BOTTOM;
            end else begin
               r_d.count = r_q.count + COUNT_STEP;
            end
         end
      end

      // double buffered compare values
      if (upd_evt) begin
         r_d.cmp_a = r_q.cmp_a_buf;
         r_d.cmp_b = r_q.cmp_b_buf;
      end

      // match flag follows one tick after the match itself
      if (tick) begin
         r_d.pend = match;
      end
      set_ev = {tick & r_q.pend[1], tick & r_q.pend[0], tov_evt};

      // software writes
      clr_ev = '0;
      if (wr) begin
         case (paddr)
            CTRL_A_OFS: r_d.ctrl_a = pwdata[7:0] & CTRL_A_WMASK;
            CTRL_B_OFS: r_d.ctrl_b = pwdata[7:0] & CTRL_B_WMASK;
            COUNT_OFS: begin
               r_d.count = pwdata[15:0];
               r_d.block = 1'b1;
            end
            CMP_A_OFS:    r_d.cmp_a_buf = pwdata[15:0];
            CMP_B_OFS:    r_d.cmp_b_buf = pwdata[15:0];
            CAPT_OFS:     r_d.capt      = pwdata[15:0];
            IRQ_STAT_OFS: clr_ev        = pwdata[2:0];
            IRQ_MASK_OFS: r_d.mask      = pwdata[2:0];
            PIN_DIR_OFS:  r_d.pin_dir   = pwdata[1:0];
            default: ;
         endcase
      end
      // a flag raised in the same cycle as its clear stays set
      r_d.stat = (r_q.stat & ~clr_ev) | set_ev;

      // read data is captured in the setup phase
      if (rd_setup) begin
         case (paddr)
            CTRL_A_OFS:   r_d.rdata = {24'h000000, r_q.ctrl_a};
            CTRL_B_OFS:   r_d.rdata = {24'h000000, r_q.ctrl_b};
            COUNT_OFS:    r_d.rdata = {16'h0000, r_q.count};
            CMP_A_OFS:    r_d.rdata = {16'h0000, r_q.cmp_a_buf};
            CMP_B_OFS:    r_d.rdata = {16'h0000, r_q.cmp_b_buf};
            CAPT_OFS:     r_d.rdata = {16'h0000, r_q.capt};
            IRQ_STAT_OFS: r_d.rdata = {29'h0000000, r_q.stat};
            IRQ_MASK_OFS: r_d.rdata = {29'h0000000, r_q.mask};
            PIN_DIR_OFS:  r_d.rdata = {30'h0000000, r_q.pin_dir};
            default:      r_d.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         r_q        <= '0;
         r_q.ctrl_a <= CTRL_RESET;
         r_q.ctrl_b <= CTRL_RESET;
         r_q.dir    <= DIR_UP;
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare output channels

   always_comb begin
      ch_code[0] = r_q.ctrl_a[CHA_MODE_LSB+:2];
      ch_code[1] = r_q.ctrl_a[CHB_MODE_LSB+:2];
      ch_cmp[0]  = r_q.cmp_a;
      ch_cmp[1]  = r_q.cmp_b;
   end

   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      chan_wave_unit u_unit (
         .core_clk   (core_clk),
         .resetn     (resetn),
         .match      (match[ch]),
         .bottom_evt (tick & at_bot),
         .dir_up     (r_q.dir == DIR_UP),
         .kind       (info.kind),
         .cmp_is_top (ch_cmp[ch] == top),
         .out_mode   (ch_code[ch]),
         .toggle_ok  ((ch == 0) ? info.a_toggle_ok : 1'b0),
         .wave       (wave[ch]),
         .takeover   (takeover[ch])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // pins, bus answer and interrupt

   always_comb begin
      chan_a_wave_pin_o    = wave[0];
      chan_b_wave_pin_o    = wave[1];
      chan_a_takeover      = takeover[0];
      chan_b_takeover      = takeover[1];
      // the driver turns on only when the direction bit agrees
      chan_a_wave_pin_oe_n = ~(takeover[0] & r_q.pin_dir[0]);
      chan_b_wave_pin_oe_n = ~(takeover[1] & r_q.pin_dir[1]);
      prdata               = r_q.rdata;
      pready               = 1'b1;
      pslverr              = psel & penable & ~addr_hit(paddr);
      irq                  = |(r_q.stat & r_q.mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_dual_up_top;
      tick && info.kind == KIND_DUAL && r_q.dir == DIR_UP && at_top
      && !cnt_wr;
   endsequence

   sequence s_ctrl_a_read;
      rd_setup && paddr == CTRL_A_OFS;
   endsequence

   tick_gate_a: assert property (
      !tick && !cnt_wr |=> $stable(r_q.count))
      else $error("counter moved without a tick");
   rsv_read_a: assert property (
      s_ctrl_a_read |=> r_q.rdata[3:2] == 2'h0)
      else $error("reserved bits read nonzero");
   ctc_wrap_a: assert property (
      mode == M_CTC_CMPA && tick && r_q.count == r_q.cmp_a && !cnt_wr
      |=> r_q.count == BOTTOM)
      else $error("ctc did not clear at compare a");
   ovf_max_a: assert property (
      mode == M_NORMAL && tick && r_q.count == TOP_MAX |=> r_q.stat[IRQ_OVF])
      else $error("overflow flag missing at max");
   pc_turn_a: assert property (
      s_dual_up_top |=> r_q.dir == DIR_DOWN)
      else $error("dual slope did not turn at top");
   pc8_top_a: assert property (
      (s_dual_up_top and (mode == M_PC8 && r_q.count == TOP_8))
      |=> r_q.count == TOP_8 - COUNT_STEP)
      else $error("phase correct top not left downward");
   fast_wrap_a: assert property (
      mode == M_FAST8 && tick && r_q.count == TOP_8 && !cnt_wr
      |=> r_q.count == BOTTOM && r_q.stat[IRQ_OVF])
      else $error("fast pwm wrap or overflow wrong");
   pfc_load_a: assert property (
      mode == M_PFC_CMPA && tick && at_bot
      |=> r_q.cmp_a == $past(r_q.cmp_a_buf))
      else $error("buffer not loaded at bottom");
   pc_hold_a: assert property (
      mode == M_PC_CAPT && !(tick && at_top) |=> $stable(r_q.cmp_b))
      else $error("compare b changed away from top");
   flag_delay_a: assert property (
      tick && r_q.pend[0] |=> r_q.stat[IRQ_CMPA])
      else $error("match flag not set one tick later");
   pin_release_a: assert property (
      !r_q.pin_dir[0] |-> chan_a_wave_pin_oe_n)
      else $error("pin driven without direction bit");

endmodule : timer16_waveform_mode_ctrl

// ===== sim/pin_load.sv
module pin_load (
   // drive from the block
   input  wire logic drv,
   input  wire logic oe_n,
   // level at the load
   output logic      level
);
   timeunit 1ns;
   timeprecision 1ns;
   // board pull-down holds a released line low
   assign level = oe_n ? 1'b0 : drv;
endmodule : pin_load

// ===== sim/timer16_waveform_mode_ctrl_tb.sv
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s exp %0h got %0h", nm, e, g); end end
module timer16_waveform_mode_ctrl_tb
   import timer16_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 0, resetn = 0, psel = 0, penable = 0;
   logic        pwrite = 0, tick_pin = 0, pready, pslverr, irq;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic        ao, aoe, ato, bo, boe, bto, lva, lvb, err;
   int          n_errors = 0, cmp_count = 0, cyc = 0;
   timer16_waveform_mode_ctrl u_dut (.core_clk(core_clk), .resetn(resetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tick_pin(tick_pin), .chan_a_wave_pin_o(ao),
      .chan_a_wave_pin_oe_n(aoe), .chan_a_takeover(ato),
      .chan_b_wave_pin_o(bo), .chan_b_wave_pin_oe_n(boe),
      .chan_b_takeover(bto), .irq(irq));
   pin_load u_lda (.drv(ao), .oe_n(aoe), .level(lva));
   pin_load u_ldb (.drv(bo), .oe_n(boe), .level(lvb));
   always #25 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_cyc
   // clears flags, then polls until the chosen one rises
   task automatic poll(input int b);
      int i;
      apb(IRQ_STAT_OFS, 1'b1, 32'h7);
      r = '0;
      for (i = 0; i < 400 && r[b] !== 1'b1; i++) apb(IRQ_STAT_OFS, 1'b0, 0);
      `CHK("flag", 1'b1, r[b])
   endtask : poll
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(CTRL_A_OFS, 1'b0, 0); `CHK("ctrl_a rst", 32'h0, r)
      `CHK("pin a rst", 1'b0, lva)
      apb(CTRL_A_OFS, 1'b1, 32'hFF);
      apb(CTRL_A_OFS, 1'b0, 0); `CHK("ctrl_a", 32'hF3, r)
      apb(CTRL_B_OFS, 1'b1, 32'hFF);
      apb(CTRL_B_OFS, 1'b0, 0); `CHK("ctrl_b", 32'h1F, r)
      apb(12'h0FC, 1'b0, 0); `CHK("unmapped", 1'b1, err)
      apb(CTRL_A_OFS, 1'b1, 0);
      apb(CTRL_B_OFS, 1'b1, 0);
   endtask : t_regs
   // four rising pin edges, each seen after the two-flop synchroniser
   task automatic t_pin();
      apb(CTRL_B_OFS, 1'b1, {29'h0, TSEL_RISE});
      apb(COUNT_OFS, 1'b1, 0);
      repeat (4) begin
         tick_pin <= 1'b1;
         wait_cyc(4);
         tick_pin <= 1'b0;
         wait_cyc(4);
      end
      apb(COUNT_OFS, 1'b0, 0); `CHK("pin count", 32'h4, r)
      apb(CTRL_B_OFS, 1'b1, 0);
   endtask : t_pin
   task automatic t_ovf();
      apb(IRQ_MASK_OFS, 1'b1, 32'h7);
      apb(CTRL_B_OFS, 1'b1, {29'h0, TSEL_DIV1});
      // start below max so the overflow lands after poll clears the flags
      apb(COUNT_OFS, 1'b1, 32'hFFF0);
      poll(IRQ_OVF);
      `CHK("irq", 1'b1, irq)
      apb(IRQ_STAT_OFS, 1'b1, 32'h7);
      apb(IRQ_STAT_OFS, 1'b0, 0); `CHK("ovf clr", 1'b0, r[0])
   endtask : t_ovf
   task automatic t_nonpwm();
      apb(PIN_DIR_OFS, 1'b1, 32'h3);
      apb(CMP_A_OFS, 1'b1, 32'h20);
      apb(CMP_B_OFS, 1'b1, 32'h20);
      apb(COUNT_OFS, 1'b1, 0);
      apb(CTRL_A_OFS, 1'b1, 32'h70); // a toggles, b sets
      wait_cyc(1);
      `CHK("take a", 1'b1, ato)
      `CHK("take b", 1'b1, bto)
      poll(IRQ_CMPA);
      `CHK("toggle a", 1'b1, lva)
      `CHK("set b", 1'b1, lvb)
   endtask : t_nonpwm
   // mode 13 never written: it is reserved
   task automatic t_pwm(input logic [7:0] ca, input logic [7:0] cb,
                        input logic ea, input logic eb);
      apb(CMP_A_OFS, 1'b1, 32'h40);
      apb(CMP_B_OFS, 1'b1, 32'h40);
      apb(CTRL_A_OFS, 1'b1, {24'h0, ca});
      apb(CTRL_B_OFS, 1'b1, {24'h0, cb});
      poll(IRQ_OVF);
      poll(IRQ_OVF);
      wait_cyc(20);
      `CHK("low a", ea, lva)
      `CHK("low b", eb, lvb)
      wait_cyc(60);
      `CHK("high a", ~ea, lva)
      `CHK("high b", ~eb, lvb)
   endtask : t_pwm
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      t_regs();
      t_pin();
      t_ovf();
      t_nonpwm();
      t_pwm(8'hB1, 8'h09, 1'b1, 1'b0);
      t_pwm(8'hB1, 8'h01, 1'b1, 1'b0);
      end_sim();
   end
endmodule : timer16_waveform_mode_ctrl_tb
